/* File: logic/bfm_pkg.sv */
// Package for the block transfer engine: register map, fields, codes, types.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit display memory port.
package bfm_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [8:0] BFM_IDX_CTRL = 9'h100;
  localparam logic [8:0] BFM_IDX_DEPTH = 9'h101;
  localparam logic [8:0] BFM_IDX_ROP = 9'h102;
  localparam logic [8:0] BFM_IDX_OPSEL = 9'h103;
  localparam logic [8:0] BFM_IDX_SRC0 = 9'h104;
  localparam logic [8:0] BFM_IDX_SRC1 = 9'h105;
  localparam logic [8:0] BFM_IDX_SRC2 = 9'h106;
  localparam logic [8:0] BFM_IDX_DST0 = 9'h108;
  localparam logic [8:0] BFM_IDX_DST1 = 9'h109;
  localparam logic [8:0] BFM_IDX_DST2 = 9'h10a;
  localparam logic [8:0] BFM_IDX_STR0 = 9'h10c;
  localparam logic [8:0] BFM_IDX_STR1 = 9'h10d;
  localparam logic [8:0] BFM_IDX_WID0 = 9'h110;
  localparam logic [8:0] BFM_IDX_WID1 = 9'h111;
  localparam logic [8:0] BFM_IDX_HGT0 = 9'h112;
  localparam logic [8:0] BFM_IDX_HGT1 = 9'h113;
  localparam logic [8:0] BFM_IDX_FG0 = 9'h118;
  localparam logic [8:0] BFM_IDX_FG1 = 9'h119;
  localparam logic [8:0] BFM_IDX_DATA = 9'h120;

  // ---------------------------------------------------------------
  // Fields and codes
  // ---------------------------------------------------------------
  localparam int BFM_CTRL_RUN_BIT = 7;
  localparam int BFM_CTRL_FULL_BIT = 4;
  localparam int BFM_CTRL_DLIN_BIT = 1;
  localparam int BFM_CTRL_SLIN_BIT = 0;
  localparam int BFM_DEPTH16_BIT = 0;
  localparam logic [7:0] BFM_CTRL_START = 8'h80;
  localparam logic [7:0] BFM_DEPTH_16 = 8'h01;
  localparam logic [7:0] BFM_OP_MOVE_FWD = 8'h02;
  localparam logic [7:0] BFM_OP_MOVE_BWD = 8'h03;
  localparam logic [7:0] BFM_OP_EXPAND = 8'h08;
  localparam logic [7:0] BFM_OP_EXPAND_TR = 8'h09;
  localparam logic [7:0] BFM_OP_FILL = 8'h0c;
  localparam logic [7:0] BFM_ROP_SRC = 8'h0c;
  localparam logic [7:0] BFM_REG_RESET = 8'h00;
  localparam logic [3:0] BFM_BIT_HIGH_START = 4'h8;
  localparam logic [3:0] BFM_BIT_LAST = 4'hf;
  localparam logic [23:0] BFM_PIX8 = 24'h000001;
  localparam logic [23:0] BFM_PIX16 = 24'h000002;
  localparam logic [1:0] BFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] BFM_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    BFM_S_IDLE = 8'h01,
    BFM_S_FETCH = 8'h02,
    BFM_S_RD_S = 8'h04,
    BFM_S_WT_S = 8'h08,
    BFM_S_RD_D = 8'h10,
    BFM_S_WT_D = 8'h20,
    BFM_S_WR = 8'h40,
    BFM_S_STEP = 8'h80
  } bfm_state_t;

  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } bfm_mem_req_t;

endpackage

/* File: logic/bfm_engine.sv */
// Block transfer engine: fill, forward/backward move with raster operation,
// colour expansion with transparency, AXI4-Lite register slave.
// Assumes a display memory port that accepts on valid and ready and returns
// read data later with a one-cycle rvalid, in request order.
//
// Contract
// - In transparent expansion, one bits write foreground, zero bits write nothing.
// - Operation code 09h selects transparent expansion, distinct from 08h.
// - Transparent expansion never uses any background colour.
// - Code 0Ch fills the destination rectangle with foreground; no source reads.
// - Foreground is two bytes at 118h/119h, used directly at 16-bit depth.
// - Width at 110h and height at 112h are 16-bit counts minus one.
// - Destination start address is three bytes at 108h to 10Ah.
// - Source start address is three bytes at 104h to 106h.
// - Stride at 10Ch/10Dh is line pitch in words, steps between lines.
// - Writing 01h to 101h selects 16-bit pixels of two bytes.
// - Pixel is one byte at 8-bit depth, two bytes otherwise.
// - Code 02h moves forward from upper-left corners through the raster operation.
// - Code 03h moves backward from lower-right corners toward lower addresses.
// - Raster operation code at 102h; 0Ch copies source to destination.
// - Source and destination each select linear or rectangular addressing.
// - Both linear selects zero means rectangular addressing for both.
// - Writing 80h to 100h starts the programmed operation.
// - Forward move takes addresses as upper-left corners.
// - Expansion takes low byte then high byte, each from bit 7 down.
// - Source address bit 0 picks low or high byte start of first word.
// - Control bit 7 reads one while the operation runs.
// - Control bit 4 reads one while the data word holder is full.
`timescale 1ns/1ns
module bfm_engine #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Display memory port
  output logic mem_valid,
  output bfm_pkg::bfm_mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata
);
  import bfm_pkg::*;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] rop_apply(input logic [7:0] code, input logic [15:0] s,
                                            input logic [15:0] d);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = code[{s[i], d[i]}];
    end
    return r;
  endfunction

  function automatic logic [23:0] addr_step(input logic [23:0] a, input logic down,
                                            input logic [23:0] amt);
    return down ? a - amt : a + amt;
  endfunction

  function automatic logic [8:0] reg_index(input logic [AW-1:0] a);
    return a[10:2];
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0] lin_r;
  logic [7:0] depth_r, rop_r, opsel_r;
  logic [23:0] src_r, dst_r;
  logic [15:0] stride_r, wid_r, hgt_r, fg_r;
  logic [15:0] buf_r;
  logic buf_full_r;
  logic running_r;
  bfm_state_t state_r;

  // ---------------------------------------------------------------
  // AXI write path
  // ---------------------------------------------------------------
  logic aw_held_r, w_held_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [8:0] widx;
  logic wr_lane0;
  logic w_mapped;
  logic start_pulse;
  logic buf_take;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign widx = reg_index(awaddr_r);
  assign wr_lane0 = do_write && wstrb_r[0];

  always_comb begin
    case (widx)
      BFM_IDX_CTRL, BFM_IDX_DEPTH, BFM_IDX_ROP, BFM_IDX_OPSEL, BFM_IDX_SRC0, BFM_IDX_SRC1,
      BFM_IDX_SRC2, BFM_IDX_DST0, BFM_IDX_DST1, BFM_IDX_DST2, BFM_IDX_STR0, BFM_IDX_STR1,
      BFM_IDX_WID0, BFM_IDX_WID1, BFM_IDX_HGT0, BFM_IDX_HGT1, BFM_IDX_FG0, BFM_IDX_FG1,
      BFM_IDX_DATA: w_mapped = (awaddr_r[AW-1:11] == '0);
      default: w_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BFM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? BFM_RESP_OKAY : BFM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Start only from idle
  assign start_pulse = wr_lane0 && w_mapped && widx == BFM_IDX_CTRL &&
                       wdata_r[BFM_CTRL_RUN_BIT] && !running_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lin_r <= 2'b00;
      depth_r <= BFM_REG_RESET;
      rop_r <= BFM_REG_RESET;
      opsel_r <= BFM_REG_RESET;
      src_r <= 24'h000000;
      dst_r <= 24'h000000;
      stride_r <= 16'h0000;
      wid_r <= 16'h0000;
      hgt_r <= 16'h0000;
      fg_r <= 16'h0000;
    end else if (wr_lane0 && w_mapped) begin
      case (widx)
        BFM_IDX_CTRL: lin_r <= {wdata_r[BFM_CTRL_DLIN_BIT], wdata_r[BFM_CTRL_SLIN_BIT]};
        BFM_IDX_DEPTH: depth_r <= wdata_r[7:0];
        BFM_IDX_ROP: rop_r <= wdata_r[7:0];
        BFM_IDX_OPSEL: opsel_r <= wdata_r[7:0];
        BFM_IDX_SRC0: src_r[7:0] <= wdata_r[7:0];
        BFM_IDX_SRC1: src_r[15:8] <= wdata_r[7:0];
        BFM_IDX_SRC2: src_r[23:16] <= wdata_r[7:0];
        BFM_IDX_DST0: dst_r[7:0] <= wdata_r[7:0];
        BFM_IDX_DST1: dst_r[15:8] <= wdata_r[7:0];
        BFM_IDX_DST2: dst_r[23:16] <= wdata_r[7:0];
        BFM_IDX_STR0: stride_r[7:0] <= wdata_r[7:0];
        BFM_IDX_STR1: stride_r[15:8] <= wdata_r[7:0];
        BFM_IDX_WID0: wid_r[7:0] <= wdata_r[7:0];
        BFM_IDX_WID1: wid_r[15:8] <= wdata_r[7:0];
        BFM_IDX_HGT0: hgt_r[7:0] <= wdata_r[7:0];
        BFM_IDX_HGT1: hgt_r[15:8] <= wdata_r[7:0];
        BFM_IDX_FG0: fg_r[7:0] <= wdata_r[7:0];
        BFM_IDX_FG1: fg_r[15:8] <= wdata_r[7:0];
        default: lin_r <= lin_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Host source word holder
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r <= 16'h0000;
      buf_full_r <= 1'b0;
    end else begin
      if (do_write && w_mapped && widx == BFM_IDX_DATA && !buf_full_r && running_r) begin
        buf_r <= wdata_r[15:0];
        buf_full_r <= 1'b1;
      end else if (buf_take) begin
        buf_full_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI read path
  // ---------------------------------------------------------------
  logic [8:0] ridx;
  logic [7:0] rbyte;
  logic r_ok;

  assign s_axi_arready = !s_axi_rvalid;
  assign ridx = reg_index(s_axi_araddr);

  always_comb begin
    rbyte = 8'h00;
    r_ok = (s_axi_araddr[AW-1:11] == '0);
    case (ridx)
      BFM_IDX_CTRL: begin
        rbyte[BFM_CTRL_RUN_BIT] = running_r;
        rbyte[BFM_CTRL_FULL_BIT] = buf_full_r;
        rbyte[BFM_CTRL_DLIN_BIT] = lin_r[1];
        rbyte[BFM_CTRL_SLIN_BIT] = lin_r[0];
      end
      BFM_IDX_DEPTH: rbyte = depth_r;
      BFM_IDX_ROP: rbyte = rop_r;
      BFM_IDX_OPSEL: rbyte = opsel_r;
      BFM_IDX_SRC0: rbyte = src_r[7:0];
      BFM_IDX_SRC1: rbyte = src_r[15:8];
      BFM_IDX_SRC2: rbyte = src_r[23:16];
      BFM_IDX_DST0: rbyte = dst_r[7:0];
      BFM_IDX_DST1: rbyte = dst_r[15:8];
      BFM_IDX_DST2: rbyte = dst_r[23:16];
      BFM_IDX_STR0: rbyte = stride_r[7:0];
      BFM_IDX_STR1: rbyte = stride_r[15:8];
      BFM_IDX_WID0: rbyte = wid_r[7:0];
      BFM_IDX_WID1: rbyte = wid_r[15:8];
      BFM_IDX_HGT0: rbyte = hgt_r[7:0];
      BFM_IDX_HGT1: rbyte = hgt_r[15:8];
      BFM_IDX_FG0: rbyte = fg_r[7:0];
      BFM_IDX_FG1: rbyte = fg_r[15:8];
      BFM_IDX_DATA: rbyte = 8'h00;
      default: r_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= BFM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rbyte};
      s_axi_rresp <= r_ok ? BFM_RESP_OKAY : BFM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Walk state
  // ---------------------------------------------------------------
  logic [23:0] scur_r, sline_r, dcur_r, dline_r;
  logic [15:0] x_r, y_r, sdat_r, res_r, word_r;
  logic [3:0] bitpos_r;
  logic is_fill, is_move, is_exp, down, wide;
  logic [23:0] pix_b, stride_b;
  logic [3:0] bit_first;
  logic cur_bit;
  logic last_x, last_y;
  logic [15:0] rd_pix;

  assign is_fill = opsel_r == BFM_OP_FILL;
  assign is_move = opsel_r == BFM_OP_MOVE_FWD || opsel_r == BFM_OP_MOVE_BWD;
  assign is_exp = opsel_r == BFM_OP_EXPAND_TR;
  assign down = opsel_r == BFM_OP_MOVE_BWD;
  assign wide = depth_r[BFM_DEPTH16_BIT];
  assign pix_b = wide ? BFM_PIX16 : BFM_PIX8;
  assign stride_b = {7'h00, stride_r, 1'b0};
  assign bit_first = src_r[0] ? BFM_BIT_HIGH_START : 4'h0;
  // Low byte bits 7..0, then high byte bits 15..8
  assign cur_bit = word_r[bitpos_r[3] ? 4'd15 - {1'b0, bitpos_r[2:0]}
                                      : 4'd7 - {1'b0, bitpos_r[2:0]}];
  assign last_x = x_r == wid_r;
  assign last_y = y_r == hgt_r;
  assign buf_take = state_r == BFM_S_FETCH && buf_full_r;
  assign rd_pix = wide ? mem_rdata : {8'h00, mem_req.addr[0] ? mem_rdata[15:8]
                                                            : mem_rdata[7:0]};

  // Memory request from held addresses and result
  always_comb begin
    mem_req.we = state_r == BFM_S_WR;
    mem_req.addr = (state_r == BFM_S_RD_S || state_r == BFM_S_WT_S) ? scur_r : dcur_r;
    mem_req.wdata = wide ? res_r : {res_r[7:0], res_r[7:0]};
    if (wide) begin
      mem_req.be = 2'b11;
    end else begin
      mem_req.be = mem_req.addr[0] ? 2'b10 : 2'b01;
    end
  end
  // Zero bits in expansion raise no request at all
  assign mem_valid = state_r == BFM_S_RD_S || state_r == BFM_S_RD_D ||
                     (state_r == BFM_S_WR && !(is_exp && !cur_bit));

  // ---------------------------------------------------------------
  // Engine state machine
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= BFM_S_IDLE;
      running_r <= 1'b0;
      scur_r <= 24'h000000;
      sline_r <= 24'h000000;
      dcur_r <= 24'h000000;
      dline_r <= 24'h000000;
      x_r <= 16'h0000;
      y_r <= 16'h0000;
      sdat_r <= 16'h0000;
      res_r <= 16'h0000;
      word_r <= 16'h0000;
      bitpos_r <= 4'h0;
    end else begin
      case (state_r)
        BFM_S_IDLE: begin
          if (start_pulse && (is_fill || is_move || is_exp)) begin
            running_r <= 1'b1;
            scur_r <= src_r;
            sline_r <= src_r;
            dcur_r <= dst_r;
            dline_r <= dst_r;
            x_r <= 16'h0000;
            y_r <= 16'h0000;
            bitpos_r <= bit_first;
            res_r <= fg_r;
            if (is_fill) begin
              state_r <= BFM_S_WR;
            end else if (is_move) begin
              state_r <= BFM_S_RD_S;
            end else begin
              state_r <= BFM_S_FETCH;
            end
          end
        end
        BFM_S_FETCH: begin
          if (buf_full_r) begin
            word_r <= buf_r;
            state_r <= BFM_S_WR;
          end
        end
        BFM_S_RD_S: begin
          if (mem_ready) begin
            state_r <= BFM_S_WT_S;
          end
        end
        BFM_S_WT_S: begin
          if (mem_rvalid) begin
            sdat_r <= rd_pix;
            state_r <= BFM_S_RD_D;
          end
        end
        BFM_S_RD_D: begin
          if (mem_ready) begin
            state_r <= BFM_S_WT_D;
          end
        end
        BFM_S_WT_D: begin
          if (mem_rvalid) begin
            res_r <= rop_apply(rop_r, sdat_r, rd_pix);
            state_r <= BFM_S_WR;
          end
        end
        BFM_S_WR: begin
          // Zero bits in expansion skip the write, no background used
          if (is_exp && !cur_bit) begin
            state_r <= BFM_S_STEP;
          end else if (mem_ready) begin
            state_r <= BFM_S_STEP;
          end
        end
        BFM_S_STEP: begin
          if (last_x && last_y) begin
            running_r <= 1'b0;
            state_r <= BFM_S_IDLE;
          end else begin
            if (last_x) begin
              x_r <= 16'h0000;
              y_r <= y_r + 16'h0001;
              // Linear continues after the last pixel; rectangular adds the stride
              if (lin_r[1]) begin
                dcur_r <= addr_step(dcur_r, down, pix_b);
                dline_r <= addr_step(dcur_r, down, pix_b);
              end else begin
                dcur_r <= addr_step(dline_r, down, stride_b);
                dline_r <= addr_step(dline_r, down, stride_b);
              end
              if (lin_r[0]) begin
                scur_r <= addr_step(scur_r, down, pix_b);
                sline_r <= addr_step(scur_r, down, pix_b);
              end else begin
                scur_r <= addr_step(sline_r, down, stride_b);
                sline_r <= addr_step(sline_r, down, stride_b);
              end
            end else begin
              x_r <= x_r + 16'h0001;
              dcur_r <= addr_step(dcur_r, down, pix_b);
              scur_r <= addr_step(scur_r, down, pix_b);
            end
            if (is_exp) begin
              if (last_x) begin
                bitpos_r <= bit_first;
                state_r <= BFM_S_FETCH;
              end else if (bitpos_r == BFM_BIT_LAST) begin
                bitpos_r <= 4'h0;
                state_r <= BFM_S_FETCH;
              end else begin
                bitpos_r <= bitpos_r + 4'h1;
                state_r <= BFM_S_WR;
              end
            end else if (is_move) begin
              state_r <= BFM_S_RD_S;
            end else begin
              state_r <= BFM_S_WR;
            end
          end
        end
        default: state_r <= BFM_S_IDLE;
      endcase
    end
  end

endmodule

/* File: testbench/bfm_mem_model.sv */
// Display memory model: 1024 words of 16 bits with byte lanes.
// Assumes one read outstanding; slow adds wait cycles.
`timescale 1ns/1ns
module bfm_mem_model (
  // Clock and pace
  input wire logic aclk,
  input wire logic slow,
  // Request port
  input wire logic mem_valid,
  input wire bfm_pkg::bfm_mem_req_t mem_req,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  import bfm_pkg::*;
  logic [15:0] mem [1024];
  logic [15:0] last_r = 16'h0000;
  logic pend_r = 1'b0, rv_r = 1'b0;
  logic [1:0] wait_r = 2'h0;
  logic [9:0] wa;
  logic go;
  assign wa = mem_req.addr[10:1];
  assign go = pend_r && (!slow || wait_r == 2'h3);
  assign mem_ready = !pend_r && (!slow || wait_r[0]);
  assign mem_rvalid = rv_r;
  // Released data shows the stored word; otherwise the inverse word
  assign mem_rdata = rv_r ? last_r : ~last_r;
  always @(posedge aclk) begin
    wait_r <= wait_r + 2'h1;
    rv_r <= go;
    if (go) pend_r <= 1'b0;
    if (mem_valid && mem_ready && mem_req.we) begin
      if (mem_req.be[0]) mem[wa][7:0] <= mem_req.wdata[7:0];
      if (mem_req.be[1]) mem[wa][15:8] <= mem_req.wdata[15:8];
    end
    if (mem_valid && mem_ready && !mem_req.we) begin
      last_r <= mem[wa];
      pend_r <= 1'b1;
    end
  end
endmodule

/* File: testbench/bfm_engine_asserts.sv */
// Port checker for the block transfer engine.
// Assumes it is bound to every engine instance.
`timescale 1ns/1ns
module bfm_engine_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port
  input wire logic mem_valid,
  input wire bfm_pkg::bfm_mem_req_t mem_req,
  input wire logic mem_ready
);
  import bfm_pkg::*;
  // --
  // Properties
  // --
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_write_once:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_once:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_mem_hold:
    assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("memory request changed");
  a_lane_word:
    assert property (mem_valid && mem_req.we && mem_req.be == 2'h3 |-> !mem_req.addr[0])
    else $error("word write misaligned");
  a_lane_byte:
    assert property (mem_valid && mem_req.we && mem_req.be != 2'h3
      |-> mem_req.be == {mem_req.addr[0], !mem_req.addr[0]}
      && mem_req.wdata[15:8] == mem_req.wdata[7:0]) else $error("byte lane wrong");
  a_quiet_reset:
    assert property ($rose(aresetn) |-> (!mem_valid) [*2])
    else $error("memory busy after reset");
  c_mem_write: cover property (mem_valid && mem_ready && mem_req.we);
  c_mem_read: cover property (mem_valid && mem_ready && !mem_req.we);
  c_mem_stall: cover property (mem_valid && !mem_ready);
endmodule
bind bfm_engine bfm_engine_asserts i_bfm_engine_asserts (.*);

/* File: testbench/blit_fill_move_engine_test.sv */
// Testbench for the block transfer engine: register tasks and blit scenarios.
// Assumes the engine package and the display memory model.
`timescale 1ns/1ns
module blit_fill_move_engine_test;
  import bfm_pkg::*;
  // --
  // Bench
  // --
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, slow = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic mem_valid, mem_ready, mem_rvalid;
  logic [15:0] mem_rdata;
  bfm_mem_req_t mem_req;
  logic [7:0] mop [3] = '{BFM_OP_MOVE_FWD, BFM_OP_MOVE_FWD, BFM_OP_MOVE_BWD};
  logic [7:0] mctl [3] = '{BFM_CTRL_START, BFM_CTRL_START | 8'h02, BFM_CTRL_START};
  logic [23:0] msrc [3] = '{24'h300, 24'h300, 24'h312};
  logic [23:0] mdst [3] = '{24'h340, 24'h380, 24'h314};
  int mbase [3] = '{416, 448, 385};
  int mls [3] = '{8, 2, 8};
  int fails = 0, check_count = 0, cyc = 0;
  always #20 aclk = ~aclk;
  bfm_engine i_bfm_engine (.*);
  bfm_mem_model i_bfm_mem_model (.*);
  function automatic logic [15:0] pre(input int i);
    return {~i[7:0], i[7:0]};
  endfunction
  function automatic logic [15:0] mw(input int i);
    return i_bfm_mem_model.mem[i];
  endfunction
  task automatic results;
    $display("checks %0d, wrong %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] idx, input logic [15:0] d);
    logic a, w, b;
    s_axi_awaddr <= {1'b0, idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
  endtask
  task automatic rd(input logic [8:0] idx);
    logic a, v;
    s_axi_araddr <= {1'b0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_arready;
      v = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end while (!v);
  endtask
  task automatic geom(input logic [15:0] w, input logic [15:0] h);
    wr(BFM_IDX_WID0, w[7:0]);
    wr(BFM_IDX_WID1, w[15:8]);
    wr(BFM_IDX_HGT0, h[7:0]);
    wr(BFM_IDX_HGT1, h[15:8]);
    wr(BFM_IDX_STR0, 16'h0008);
    wr(BFM_IDX_STR1, 16'h0000);
  endtask
  task automatic start(input logic [7:0] op, input logic [23:0] s, input logic [23:0] d,
                       input logic [7:0] ctl);
    wr(BFM_IDX_OPSEL, op);
    wr(BFM_IDX_SRC0, s[7:0]);
    wr(BFM_IDX_SRC1, s[15:8]);
    wr(BFM_IDX_SRC2, s[23:16]);
    wr(BFM_IDX_DST0, d[7:0]);
    wr(BFM_IDX_DST1, d[15:8]);
    wr(BFM_IDX_DST2, d[23:16]);
    wr(BFM_IDX_CTRL, ctl);
    rd(BFM_IDX_CTRL);
    cmp({15'h0, rv[BFM_CTRL_RUN_BIT]}, 16'h0001);
  endtask
  task automatic drain;
    while (rv[BFM_CTRL_RUN_BIT] === 1'b1) rd(BFM_IDX_CTRL);
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) i_bfm_mem_model.mem[i] = pre(i);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(BFM_IDX_FG0, 16'h00a5);
    cmp({14'h0, br}, {14'h0, BFM_RESP_OKAY});
    rd(BFM_IDX_FG0);
    cmp(rv[15:0], 16'h00a5);
    rd(9'h0ff);
    cmp({14'h0, rr}, {14'h0, BFM_RESP_SLVERR});
    wr(9'h0ff, 16'h0000);
    cmp({14'h0, br}, {14'h0, BFM_RESP_SLVERR});
    wr(BFM_IDX_DEPTH, BFM_DEPTH_16);
    wr(BFM_IDX_FG1, 16'h00f8);
    wr(BFM_IDX_FG0, 16'h0000);
    geom(16'h2, 16'h1);
    start(BFM_OP_FILL, 24'h0, 24'h000100, BFM_CTRL_START);
    drain;
    for (int k = 0; k < 16; k++)
      cmp(mw(128 + k), (k % 8) < 3 ? 16'hf800 : pre(128 + k));
    wr(BFM_IDX_DEPTH, 16'h0000);
    wr(BFM_IDX_FG0, 16'h003c);
    geom(16'h2, 16'h0);
    start(BFM_OP_FILL, 24'h0, 24'h000201, BFM_CTRL_START);
    drain;
    cmp(mw(256), 16'h3c00);
    cmp(mw(257), 16'h3c3c);
    cmp(mw(258), pre(258));
    wr(BFM_IDX_DEPTH, BFM_DEPTH_16);
    wr(BFM_IDX_ROP, BFM_ROP_SRC);
    geom(16'h1, 16'h1);
    for (int k = 0; k < 3; k++) begin
      slow <= (k == 2);
      start(mop[k], msrc[k], mdst[k], mctl[k]);
      drain;
      for (int p = 0; p < 4; p++)
        cmp(mw(mbase[k] + mls[k] * (p / 2) + p % 2), pre(384 + 8 * (p / 2) + p % 2));
    end
    wr(BFM_IDX_FG0, 16'h0034);
    wr(BFM_IDX_FG1, 16'h0012);
    for (int k = 0; k < 2; k++) begin
      geom(k ? 16'h3 : 16'h7, 16'h0);
      start(BFM_OP_EXPAND_TR, {23'h0, k[0]}, 24'h000400 + 24'h20 * k, BFM_CTRL_START);
      rd(BFM_IDX_CTRL);
      cmp({15'h0, rv[BFM_CTRL_FULL_BIT]}, 16'h0000);
      wr(BFM_IDX_DATA, 16'hc3a5);
      drain;
      for (int p = 0; p < 8; p++)
        cmp(mw(512 + 16 * k + p), (p < 8 - 4 * k && (k ? 8'hc3 : 8'ha5) >> (7 - p) & 1)
            ? 16'h1234 : pre(512 + 16 * k + p));
    end
    results;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results;
    end
  end
endmodule
